// >>> rtt_timer.sv
// countdown timer and second/minute tick logic with register port and interrupt output
`timescale 1ns/1ns
`default_nettype none
`include "rtt_params.svh"
// Notes on behaviour
// - top control bit runs timer, reset off
// - two-bit field picks 4k, 64, 1, 1/60 Hz
// - period equals value over source frequency
// - tick enables pick none, minute or second
// - tick flag set on chosen counter increment
// - minute-only flag self-clears after one second
// - tick pulse produced regardless of flag state
// - value zero halts, one to 255 valid
// - at one: flag, reload, next period
// - countdown read returns live counter
// - written value takes effect at once
// - first period between T and T+1
// - done flag sticky until host clears
// - pulse or level form, enable suppresses
// - status write clears only zero-written flags
// - done flag bit 2, tick flag bit 5
// - tick pulse lasts one 64 Hz period
module rtt_timer #(
   parameter int DIV_4K = `RTT_DIV_4K
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_wr_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   output logic [7:0] o_rd_data,
   output logic o_int_n
);
   localparam logic [15:0] DIV_LAST = 16'(DIV_4K - 1);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // prescaler: 4.096 kHz enable, then 64 Hz, 1 Hz and one per minute
   logic [15:0] div_r, div_nxt;
   logic [5:0] p64_r, p64_nxt, p1_r, p1_nxt, sec_r, sec_nxt;
   logic tick4k, tick64, tick1, tickmin;

   assign tick4k = (div_r == DIV_LAST);
   assign tick64 = tick4k && (p64_r == `RTT_PRE_LAST);
   assign tick1 = tick64 && (p1_r == `RTT_PRE_LAST);
   assign tickmin = tick1 && (sec_r == `RTT_SEC_LAST);

   always_comb begin
      div_nxt = tick4k ? 16'h0000 : div_r + 16'h0001;
      p64_nxt = p64_r;
      p1_nxt = p1_r;
      sec_nxt = sec_r;
      if (tick4k) begin
         p64_nxt = p64_r + 6'h01;
      end
      if (tick64) begin
         p1_nxt = p1_r + 6'h01;
      end
      if (tick1) begin
         sec_nxt = (sec_r == `RTT_SEC_LAST) ? 6'h00 : sec_r + 6'h01;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         div_r <= 16'h0000;
         p64_r <= 6'h00;
         p1_r <= 6'h00;
         sec_r <= 6'h00;
      end else begin
         div_r <= div_nxt;
         p64_r <= p64_nxt;
         p1_r <= p1_nxt;
         sec_r <= sec_nxt;
      end
   end

   // registers, countdown, flags and interrupt
   logic run_r, run_nxt, arm_r, arm_nxt;
   rtt_pkg::rtt_src_e sel_r, sel_nxt;
   logic [7:0] cnt_r, cnt_nxt, reload_r, reload_nxt, rd_r, rd_nxt;
   logic min_en_r, min_en_nxt, si_r, si_nxt, tp_r, tp_nxt, tie_r, tie_nxt;
   logic tick_flag_r, tick_flag_nxt, done_flag_r, done_flag_nxt, auto_r, auto_nxt;
   logic msp_r, msp_nxt, cdp_r, cdp_nxt, int_n_r, int_n_nxt;
   logic wr_c2, wr_tc, wr_cd, src_tick, pclk, flag_set, cd_done, cd_step;

   assign wr_c2 = i_wr_en && hit(i_addr, `RTT_ADDR_CTRL2);
   assign wr_tc = i_wr_en && hit(i_addr, `RTT_ADDR_TCTRL);
   assign wr_cd = i_wr_en && hit(i_addr, `RTT_ADDR_CDVAL);

   always_comb begin
      case (sel_r)
         rtt_pkg::RTT_SRC_4K: src_tick = tick4k;
         rtt_pkg::RTT_SRC_64: src_tick = tick64;
         rtt_pkg::RTT_SRC_1: src_tick = tick1;
         default: src_tick = tickmin;
      endcase
   end

   // the done pulse is timed from the source clock at 4 kHz, else from 64 Hz
   assign pclk = (sel_r == rtt_pkg::RTT_SRC_4K) ? tick4k : tick64;
   assign flag_set = si_r ? tick1 : (min_en_r && tickmin);
   // zero in the counter halts it
   assign cd_step = run_r && src_tick && !arm_r && (cnt_r != 8'h00);
   assign cd_done = cd_step && (cnt_r == 8'h01);

   always_comb begin
      run_nxt = run_r;
      sel_nxt = sel_r;
      arm_nxt = arm_r;
      cnt_nxt = cnt_r;
      reload_nxt = reload_r;
      min_en_nxt = min_en_r;
      si_nxt = si_r;
      tp_nxt = tp_r;
      tie_nxt = tie_r;
      tick_flag_nxt = tick_flag_r;
      done_flag_nxt = done_flag_r;
      auto_nxt = auto_r;
      msp_nxt = msp_r;
      cdp_nxt = cdp_r;
      if (wr_tc) begin
         run_nxt = i_wr_data[`RTT_TC_RUN];
         sel_nxt = rtt_pkg::rtt_src_e'(i_wr_data[1:0]);
         // enabling skips the first partial source tick
         if (!run_r && i_wr_data[`RTT_TC_RUN]) begin
            arm_nxt = 1'b1;
         end
      end
      if (run_r && src_tick && arm_r) begin
         arm_nxt = 1'b0;
      end
      if (cd_done) begin
         cnt_nxt = reload_r;
      end else if (cd_step) begin
         cnt_nxt = cnt_r - 8'h01;
      end
      if (wr_cd) begin
         reload_nxt = i_wr_data;
         cnt_nxt = i_wr_data;
      end
      if (wr_c2) begin
         min_en_nxt = i_wr_data[`RTT_C2_MIN_EN];
         si_nxt = i_wr_data[`RTT_C2_SI];
         tp_nxt = i_wr_data[`RTT_C2_TP];
         tie_nxt = i_wr_data[`RTT_C2_TIE];
         tick_flag_nxt = tick_flag_r & i_wr_data[`RTT_C2_TICK_FLAG];
         done_flag_nxt = done_flag_r & i_wr_data[`RTT_C2_DONE_FLAG];
      end
      // minute-only flag drops at the next 1 Hz tick after it was set
      if (auto_r && tick1) begin
         tick_flag_nxt = 1'b0;
         auto_nxt = 1'b0;
      end
      if (!min_en_r || si_r) begin
         auto_nxt = 1'b0;
      end
      // a new event beats a clear in the same cycle
      if (flag_set) begin
         tick_flag_nxt = 1'b1;
         auto_nxt = min_en_r && !si_r;
      end
      if (cd_done) begin
         done_flag_nxt = 1'b1;
      end
      // tick pulse runs one 64 Hz period, done pulse one pulse-clock period, both cut short by clearing the flag
      if (flag_set) begin
         msp_nxt = 1'b1;
      end else if (tick64 || !tick_flag_nxt) begin
         msp_nxt = 1'b0;
      end
      if (cd_done) begin
         cdp_nxt = 1'b1;
      end else if (pclk || !done_flag_nxt) begin
         cdp_nxt = 1'b0;
      end
      int_n_nxt = !((tie_r && (tp_r ? cdp_r : done_flag_r)) ||
                    (tp_r ? msp_r : (tick_flag_r && (min_en_r || si_r))));
      if (hit(i_addr, `RTT_ADDR_CTRL2)) begin
         rd_nxt = {min_en_r, si_r, tick_flag_r, tp_r, 1'b0, done_flag_r, 1'b0, tie_r};
      end else if (hit(i_addr, `RTT_ADDR_TCTRL)) begin
         rd_nxt = {run_r, 5'h00, sel_r};
      end else if (hit(i_addr, `RTT_ADDR_CDVAL)) begin
         rd_nxt = cnt_r;
      end else begin
         rd_nxt = 8'h00;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         run_r <= 1'(`RTT_TC_RESET >> `RTT_TC_RUN);
         sel_r <= rtt_pkg::rtt_src_e'(2'(`RTT_TC_RESET));
         arm_r <= 1'b0;
         cnt_r <= `RTT_CD_RESET;
         reload_r <= `RTT_CD_RESET;
         min_en_r <= 1'b0;
         si_r <= 1'b0;
         tp_r <= 1'b0;
         tie_r <= 1'b0;
         tick_flag_r <= 1'b0;
         done_flag_r <= 1'b0;
         auto_r <= 1'b0;
         msp_r <= 1'b0;
         cdp_r <= 1'b0;
         int_n_r <= 1'b1;
         rd_r <= 8'h00;
      end else begin
         run_r <= run_nxt;
         sel_r <= sel_nxt;
         arm_r <= arm_nxt;
         cnt_r <= cnt_nxt;
         reload_r <= reload_nxt;
         min_en_r <= min_en_nxt;
         si_r <= si_nxt;
         tp_r <= tp_nxt;
         tie_r <= tie_nxt;
         tick_flag_r <= tick_flag_nxt;
         done_flag_r <= done_flag_nxt;
         auto_r <= auto_nxt;
         msp_r <= msp_nxt;
         cdp_r <= cdp_nxt;
         int_n_r <= int_n_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign o_rd_data = rd_r;
   assign o_int_n = int_n_r;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   a_disabled_hold: assert property (!run_r && !wr_cd |=> $stable(cnt_r))
      else $error("counter moved while disabled");
   a_second_step: assert property (run_r && sel_r == rtt_pkg::RTT_SRC_1 && tick1 && !arm_r
      && cnt_r > 8'h01 && !wr_cd |=> cnt_r == $past(cnt_r) - 8'h01)
      else $error("1 Hz source did not decrement");
   a_halt_zero: assert property (cnt_r == 8'h00 && !wr_cd |=> cnt_r == 8'h00
      && !$rose(done_flag_r))
      else $error("zero count did not halt");
   a_reload_one: assert property (cd_done && !wr_cd |=> done_flag_r
      && cnt_r == $past(reload_r))
      else $error("no reload or flag at one");
   a_live_read: assert property (hit(i_addr, `RTT_ADDR_CDVAL) |=> o_rd_data == $past(cnt_r))
      else $error("read did not return live count");
   a_write_now: assert property (wr_cd |=> cnt_r == $past(i_wr_data) && reload_r == $past(i_wr_data))
      else $error("written value not applied");
   a_first_skip: assert property (run_r && arm_r && src_tick && !wr_cd |=> $stable(cnt_r))
      else $error("first partial tick counted");
   a_tf_sticky: assert property (done_flag_r && !(wr_c2 && !i_wr_data[`RTT_C2_DONE_FLAG])
      |=> done_flag_r)
      else $error("done flag lost");
   a_flag_and: assert property (wr_c2 && !i_wr_data[`RTT_C2_TICK_FLAG] && !flag_set
      |=> !tick_flag_r)
      else $error("zero write did not clear tick flag");
   a_no_tick: assert property (!min_en_r && !si_r && !tick_flag_r && !msp_r
      |=> !tick_flag_r && !msp_r)
      else $error("tick flag set with ticks off");
   a_sec_set: assert property (si_r && tick1 |=> tick_flag_r && msp_r)
      else $error("second tick missed");
   a_auto_clear: assert property (auto_r && tick1 && !flag_set |=> !tick_flag_r)
      else $error("minute flag not self-cleared");
   a_pulse_end: assert property (msp_r && tick64 && !flag_set |=> !msp_r)
      else $error("tick pulse overran 64 Hz period");
   a_int_level: assert property (!tp_r && tie_r && done_flag_r |=> !o_int_n)
      else $error("level interrupt not driven low");
   a_int_quiet: assert property (!tie_r && !min_en_r && !si_r && !tick_flag_r && !msp_r
      |=> o_int_n)
      else $error("interrupt with all sources off");

   c_done: cover property (cd_done ##1 done_flag_r);
   c_sec: cover property (si_r && flag_set);
   c_min_auto: cover property (auto_r && tick1);
   c_pulse_int: cover property (tp_r && cdp_r ##1 !o_int_n);
endmodule
`default_nettype wire

// >>> rtt_params.svh
// offsets, field positions, reset values and timing figures of the countdown and tick timer
`ifndef RTT_PARAMS_SVH
`define RTT_PARAMS_SVH
`define RTT_ADDR_CTRL2 8'h01
`define RTT_ADDR_TCTRL 8'h0e
`define RTT_ADDR_CDVAL 8'h0f
`define RTT_C2_MIN_EN 7
`define RTT_C2_SI 6
`define RTT_C2_TICK_FLAG 5
`define RTT_C2_TP 4
`define RTT_C2_DONE_FLAG 2
`define RTT_C2_TIE 0
`define RTT_TC_RUN 7
`define RTT_C2_RESET 8'h00
`define RTT_TC_RESET 8'h03
`define RTT_CD_RESET 8'h00
`define RTT_SYS_HZ 25000000
`define RTT_SRC4K_HZ 4096
`define RTT_DIV_4K (`RTT_SYS_HZ / `RTT_SRC4K_HZ)
`define RTT_PRE_LAST 6'h3f
`define RTT_SEC_LAST 6'h3b
`endif

// >>> rtt_pkg.sv
// types shared by the countdown and tick timer
package rtt_pkg;
   typedef enum logic [1:0] {
      RTT_SRC_4K = 2'b00,
      RTT_SRC_64 = 2'b01,
      RTT_SRC_1 = 2'b10,
      RTT_SRC_MIN = 2'b11
   } rtt_src_e;
endpackage

// >>> rtt_host.sv
// host model that drives the timer register port on the falling edge
`timescale 1ns/1ns
`default_nettype none
module rtt_host (
   input wire logic i_clk_sys,
   input wire logic [7:0] i_rd_data,
   output logic o_wr_en,
   output logic [7:0] o_addr,
   output logic [7:0] o_wr_data
);
   initial begin
      o_wr_en = 1'b0;
      o_addr = 8'h00;
      o_wr_data = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk_sys);
      o_wr_en = 1'b1;
      o_addr = a;
      o_wr_data = d;
      @(negedge i_clk_sys);
      o_wr_en = 1'b0;
      // stale data must not look like a held value
      o_wr_data = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk_sys);
      o_addr = a;
      @(negedge i_clk_sys);
      d = i_rd_data;
   endtask
   // the count cannot be frozen, so accept it only when two reads agree
   task automatic rd_count(output logic [7:0] d);
      logic [7:0] p;
      rd(8'h0f, p);
      rd(8'h0f, d);
      while (d !== p) begin
         p = d;
         rd(8'h0f, d);
      end
   endtask
   // stop the timer before changing the count
   task automatic load(input logic [7:0] t, input logic [1:0] src);
      wr(8'h0e, {6'h00, src});
      wr(8'h0f, t);
      wr(8'h0e, {1'b1, 5'h00, src});
   endtask
endmodule
`default_nettype wire

// >>> rtt_timer_bench.sv
// self-checking bench for the countdown and tick timer
`timescale 1ns/1ns
`default_nettype none
module rtt_timer_bench;
   logic i_clk_sys = 1'b0;
   logic i_resetn = 1'b0;
   logic wr_en;
   logic [7:0] addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic int_n;
   logic [7:0] v;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   always #20 i_clk_sys = ~i_clk_sys;
   // small divider keeps one second at 16384 cycles
   rtt_timer #(.DIV_4K(4)) dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wr_en(wr_en),
      .i_addr(addr), .i_wr_data(wr_data), .o_rd_data(rd_data), .o_int_n(int_n));
   rtt_host host (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data), .o_wr_en(wr_en), .o_addr(addr),
      .o_wr_data(wr_data));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wait_bit(input logic [7:0] a, input int b, input int n);
      repeat (n) begin
         host.rd(a, v);
         if (v[b] === 1'b1)
            return;
      end
   endtask
   task automatic wait_int(input logic lvl, input int n);
      repeat (n) begin
         @(negedge i_clk_sys);
         if (int_n === lvl)
            return;
      end
   endtask
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      repeat (4) @(negedge i_clk_sys);
      i_resetn = 1'b1;
      host.rd(8'h0e, v);
      check("timer_control reset", 8'h03, v);
      host.rd(8'h0f, v);
      check("countdown reset", 8'h00, v);
      host.rd(8'h01, v);
      check("control_2 reset", 8'h00, v);
      host.rd(8'h20, v);
      check("unmapped read", 8'h00, v);
      check("irq idle high", 8'h01, {7'h00, int_n});
      $display("test reset done");
      host.load(8'h00, 2'b00);
      repeat (40) @(negedge i_clk_sys);
      host.rd(8'h01, v);
      check("halted done flag", 8'h00, v);
      $display("test zero halt done");
      host.load(8'h03, 2'b00);
      host.rd_count(v);
      check("live count in range", 8'h01, {7'h00, v >= 8'h01 && v <= 8'h03});
      wait_bit(8'h01, 2, 16);
      check("done flag set", 8'h04, v);
      host.wr(8'h0e, 8'h00);
      repeat (20) @(negedge i_clk_sys);
      host.rd(8'h01, v);
      check("done flag sticky", 8'h04, v);
      host.wr(8'h01, 8'h24);
      host.rd(8'h01, v);
      check("write one keeps", 8'h04, v);
      host.wr(8'h01, 8'h05);
      wait_int(1'b0, 4);
      check("level irq low", 8'h00, {7'h00, int_n});
      host.wr(8'h01, 8'h01);
      wait_int(1'b1, 4);
      check("irq follows flag", 8'h01, {7'h00, int_n});
      host.rd(8'h01, v);
      check("write zero clears", 8'h01, v);
      host.wr(8'h0e, 8'h80);
      wait_bit(8'h01, 2, 16);
      check("reload period", 8'h05, v);
      host.load(8'h01, 2'b01);
      host.wr(8'h01, 8'h01);
      host.rd(8'h01, v);
      check("64 Hz not early", 8'h01, v);
      wait_bit(8'h01, 2, 300);
      check("64 Hz period", 8'h05, v);
      // park on the slowest source to save power when unused
      host.wr(8'h0e, 8'h03);
      host.wr(8'h01, 8'h00);
      $display("test countdown done");
      host.wr(8'h01, 8'h50);
      wait_int(1'b0, 17000);
      check("second tick pulse", 8'h00, {7'h00, int_n});
      host.rd(8'h01, v);
      check("tick flag set", 8'h70, v);
      wait_int(1'b1, 300);
      check("pulse ends", 8'h01, {7'h00, int_n});
      wait_int(1'b0, 17000);
      check("pulse despite flag", 8'h00, {7'h00, int_n});
      host.wr(8'h01, 8'h00);
      repeat (17000) @(negedge i_clk_sys);
      host.rd(8'h01, v);
      check("no tick when off", 8'h00, v);
      check("irq quiet", 8'h01, {7'h00, int_n});
      $display("test ticks done");
      close_out();
   end
endmodule
`default_nettype wire
